// ### rtl/p2pc_an_seq.sv
// Auto-negotiation progress sequencer
`timescale 1ns/100ps
`default_nettype none

module p2pc_an_seq (
  input  wire logic clock_i,
  input  wire logic rst_i,
  input  wire logic an_enable_i,
  input  wire logic power_down_i,
  input  wire logic restart_i,
  input  wire logic result_ready_i,
  input  wire logic link_drop_i,
  output logic      complete_o
);

  p2pc_pkg::an_state_t state_r;
  p2pc_pkg::an_state_t state_nxt;
  logic                run_ok;

  assign run_ok = an_enable_i & ~power_down_i;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      p2pc_pkg::AN_IDLE: begin
        if (run_ok) state_nxt = p2pc_pkg::AN_NEG;
      end
      p2pc_pkg::AN_NEG: begin
        if (!run_ok) state_nxt = p2pc_pkg::AN_IDLE;
        else if (!restart_i && result_ready_i) state_nxt = p2pc_pkg::AN_DONE;
      end
      p2pc_pkg::AN_DONE: begin
        if (!run_ok) state_nxt = p2pc_pkg::AN_IDLE;
        else if (restart_i || link_drop_i) state_nxt = p2pc_pkg::AN_NEG;
      end
      default: state_nxt = p2pc_pkg::AN_IDLE;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) state_r <= p2pc_pkg::AN_IDLE;
    else state_r <= state_nxt;
  end

  assign complete_o = (state_r == p2pc_pkg::AN_DONE);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_seq_restart;
    @(posedge clock_i) disable iff (rst_i)
    restart_i && run_ok |=> !complete_o;
  endproperty
  a_seq_restart: assert property (p_seq_restart)
    else $error("Restart left negotiation complete");

  property p_seq_done;
    @(posedge clock_i) disable iff (rst_i)
    (state_r == p2pc_pkg::AN_NEG) && run_ok && !restart_i && result_ready_i
      |=> complete_o;
  endproperty
  a_seq_done: assert property (p_seq_done)
    else $error("Negotiation result not reported complete");

endmodule : p2pc_an_seq

`default_nettype wire

// ### rtl/p2pc_cfg.svh
// Offsets, field positions, reset values for port 2 transceiver registers
`ifndef P2PC_CFG_SVH
`define P2PC_CFG_SVH

// Register indices; byte address is four times the index
`define P2PC_IDX_CTRL   3'h0
`define P2PC_IDX_STAT   3'h2
`define P2PC_IDX_ISTAT  3'h4
`define P2PC_IDX_IMASK  3'h5
`define P2PC_IDX_ALIAS  3'h6

// Basic control register fields
`define P2PC_CB_LOOP    14
`define P2PC_CB_F100    13
`define P2PC_CB_ANEN    12
`define P2PC_CB_PDOWN   11
`define P2PC_CB_RESTART 9
`define P2PC_CB_FDX     8
`define P2PC_CB_XALG    5
`define P2PC_CB_FMDIX   4
`define P2PC_CB_MDIXOFF 3
`define P2PC_CB_RSVD2   2
`define P2PC_CB_TXOFF   1
`define P2PC_CB_LEDOFF  0
`define P2PC_CTRL_RST   16'h1020
`define P2PC_CTRL_WMASK 16'h7b3f

// Position of each control field except P2PC_CB_XALG in the aliased bank register
`define P2PC_AL_LOOP    8
`define P2PC_AL_F100    6
`define P2PC_AL_ANEN    7
`define P2PC_AL_PDOWN   11
`define P2PC_AL_RESTART 13
`define P2PC_AL_FDX     5
`define P2PC_AL_FMDIX   9
`define P2PC_AL_MDIXOFF 10
`define P2PC_AL_RSVD2   12
`define P2PC_AL_TXOFF   14
`define P2PC_AL_LEDOFF  15

// Basic status register fields
`define P2PC_SB_ANDONE  5
`define P2PC_SB_FEF     4
`define P2PC_SB_ANCAP   3
`define P2PC_SB_LINK    2
`define P2PC_SB_JABBER  1

// Interrupt status bits
`define P2PC_IB_LINKUP  0
`define P2PC_IB_LINKDN  1
`define P2PC_IB_ANDONE  2
`define P2PC_IB_FEF     3
`define P2PC_IRQ_W      4

// Transceiver configuration after reset, in phy_cfg_t field order
`define P2PC_CFG_RST    10'h094

`endif

// ### rtl/p2pc_pkg.sv
// Types for the port 2 transceiver register bank
`default_nettype none

package p2pc_pkg;

  typedef enum logic [1:0] {
    AN_IDLE = 2'b00,
    AN_NEG  = 2'b01,
    AN_DONE = 2'b11
  } an_state_t;

  typedef struct packed {
    logic loopback;
    logic power_down;
    logic an_enable;
    logic speed_100;
    logic full_duplex;
    logic mdix_auto;
    logic mdix_cross;
    logic xover_std;
    logic tx_disable;
    logic led_disable;
  } phy_cfg_t;

endpackage : p2pc_pkg

`default_nettype wire

// ### rtl/p2pc_top.sv
// Port 2 transceiver basic control and status register bank
//
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none
`include "p2pc_cfg.svh"

module p2pc_top (
  input  wire logic         clock_i,
  input  wire logic         rst_i,
  input  wire logic [4:0]   avs_address_i,
  input  wire logic         avs_read_i,
  input  wire logic         avs_write_i,
  input  wire logic [31:0]  avs_writedata_i,
  input  wire logic [3:0]   avs_byteenable_i,
  output logic [31:0]       avs_readdata_o,
  output logic              avs_waitrequest_o,
  input  wire logic         link_up_i,
  input  wire logic         far_end_fault_i,
  input  wire logic         an_result_ready_i,
  input  wire logic         an_speed_100_i,
  input  wire logic         an_full_duplex_i,
  output p2pc_pkg::phy_cfg_t phy_cfg_o,
  output logic              an_restart_o,
  output logic              irq_o
);

  // ----------------------------------------
  // Field mapping
  // ----------------------------------------
  function automatic logic [15:0] ctrl_to_alias(input logic [15:0] c);
    logic [15:0] a;
    a = 16'h0000;
    a[`P2PC_AL_LOOP]    = c[`P2PC_CB_LOOP];
    a[`P2PC_AL_F100]    = c[`P2PC_CB_F100];
    a[`P2PC_AL_ANEN]    = c[`P2PC_CB_ANEN];
    a[`P2PC_AL_PDOWN]   = c[`P2PC_CB_PDOWN];
    a[`P2PC_AL_RESTART] = c[`P2PC_CB_RESTART];
    a[`P2PC_AL_FDX]     = c[`P2PC_CB_FDX];
    a[`P2PC_AL_FMDIX]   = c[`P2PC_CB_FMDIX];
    a[`P2PC_AL_MDIXOFF] = c[`P2PC_CB_MDIXOFF];
    a[`P2PC_AL_RSVD2]   = c[`P2PC_CB_RSVD2];
    a[`P2PC_AL_TXOFF]   = c[`P2PC_CB_TXOFF];
    a[`P2PC_AL_LEDOFF]  = c[`P2PC_CB_LEDOFF];
    return a;
  endfunction : ctrl_to_alias

  function automatic logic [15:0] alias_to_ctrl(input logic [15:0] a);
    logic [15:0] c;
    c = 16'h0000;
    c[`P2PC_CB_LOOP]    = a[`P2PC_AL_LOOP];
    c[`P2PC_CB_F100]    = a[`P2PC_AL_F100];
    c[`P2PC_CB_ANEN]    = a[`P2PC_AL_ANEN];
    c[`P2PC_CB_PDOWN]   = a[`P2PC_AL_PDOWN];
    c[`P2PC_CB_RESTART] = a[`P2PC_AL_RESTART];
    c[`P2PC_CB_FDX]     = a[`P2PC_AL_FDX];
    c[`P2PC_CB_FMDIX]   = a[`P2PC_AL_FMDIX];
    c[`P2PC_CB_MDIXOFF] = a[`P2PC_AL_MDIXOFF];
    c[`P2PC_CB_RSVD2]   = a[`P2PC_AL_RSVD2];
    c[`P2PC_CB_TXOFF]   = a[`P2PC_AL_TXOFF];
    c[`P2PC_CB_LEDOFF]  = a[`P2PC_AL_LEDOFF];
    return c;
  endfunction : alias_to_ctrl

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  logic                  ack_r;
  logic                  wr_go;
  logic                  rd_go;
  logic [2:0]            idx;
  logic [15:0]           bemask;
  logic [15:0]           wdata;
  logic [31:0]           rdata_r;
  logic [31:0]           rd_mux;
  logic [15:0]           ctrl_r;
  logic [15:0]           ctrl_wm;
  logic [15:0]           ctrl_wd;
  logic                  link_r;
  logic                  fef_r;
  logic                  an_done;
  logic                  an_done_r;
  logic [`P2PC_IRQ_W-1:0] ist_r;
  logic [`P2PC_IRQ_W-1:0] imask_r;
  logic [`P2PC_IRQ_W-1:0] ev;
  logic [`P2PC_IRQ_W-1:0] iclr;

  assign idx    = avs_address_i[4:2];
  assign wr_go  = avs_write_i & ack_r;
  assign rd_go  = avs_read_i & ack_r;
  assign wdata  = avs_writedata_i[15:0];
  assign bemask = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_r;
  assign avs_readdata_o    = rdata_r;

  always_ff @(posedge clock_i) begin
    if (rst_i) ack_r <= 1'b0;
    else ack_r <= (avs_read_i | avs_write_i) & ~ack_r;
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (idx)
      `P2PC_IDX_CTRL:  rd_mux[15:0] = ctrl_r & `P2PC_CTRL_WMASK;
      `P2PC_IDX_STAT: begin
        rd_mux[`P2PC_SB_ANDONE] = an_done;
        rd_mux[`P2PC_SB_FEF]    = fef_r;
        rd_mux[`P2PC_SB_ANCAP]  = 1'b1;
        rd_mux[`P2PC_SB_LINK]   = link_r;
        rd_mux[`P2PC_SB_JABBER] = 1'b0;
      end
      `P2PC_IDX_ISTAT: rd_mux[`P2PC_IRQ_W-1:0] = ist_r;
      `P2PC_IDX_IMASK: rd_mux[`P2PC_IRQ_W-1:0] = imask_r;
      `P2PC_IDX_ALIAS: rd_mux[15:0] = ctrl_to_alias(ctrl_r);
      default:         rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) rdata_r <= 32'h0000_0000;
    else if (avs_read_i && !ack_r) rdata_r <= rd_mux;
  end

  // ----------------------------------------
  // Control storage
  // ----------------------------------------
  always_comb begin
    ctrl_wm = 16'h0000;
    ctrl_wd = 16'h0000;
    if (wr_go && idx == `P2PC_IDX_CTRL) begin
      ctrl_wm = bemask & `P2PC_CTRL_WMASK;
      ctrl_wd = wdata;
    end else if (wr_go && idx == `P2PC_IDX_ALIAS) begin
      ctrl_wm = alias_to_ctrl(bemask) & `P2PC_CTRL_WMASK;
      ctrl_wd = alias_to_ctrl(wdata);
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ctrl_r <= `P2PC_CTRL_RST;
    end else begin
      ctrl_r <= (ctrl_r & ~ctrl_wm) | (ctrl_wd & ctrl_wm);
      if (!ctrl_wm[`P2PC_CB_RESTART])
        ctrl_r[`P2PC_CB_RESTART] <= 1'b0;
    end
  end

  assign an_restart_o = ctrl_r[`P2PC_CB_RESTART];

  // ----------------------------------------
  // Transceiver configuration
  // ----------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      phy_cfg_o <= `P2PC_CFG_RST;
    end else begin
      phy_cfg_o.loopback    <= ctrl_r[`P2PC_CB_LOOP];
      phy_cfg_o.power_down  <= ctrl_r[`P2PC_CB_PDOWN];
      phy_cfg_o.an_enable   <= ctrl_r[`P2PC_CB_ANEN];
      phy_cfg_o.speed_100   <= ctrl_r[`P2PC_CB_ANEN] ?
                               an_speed_100_i : ctrl_r[`P2PC_CB_F100];
      phy_cfg_o.full_duplex <= ctrl_r[`P2PC_CB_ANEN] ?
                               an_full_duplex_i : ctrl_r[`P2PC_CB_FDX];
      phy_cfg_o.mdix_auto   <= ~ctrl_r[`P2PC_CB_MDIXOFF] &
                               ~ctrl_r[`P2PC_CB_FMDIX];
      phy_cfg_o.mdix_cross  <= ctrl_r[`P2PC_CB_FMDIX];
      phy_cfg_o.xover_std   <= ctrl_r[`P2PC_CB_XALG];
      phy_cfg_o.tx_disable  <= ctrl_r[`P2PC_CB_TXOFF];
      phy_cfg_o.led_disable <= ctrl_r[`P2PC_CB_LEDOFF];
    end
  end

  // ----------------------------------------
  // Status and negotiation
  // ----------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      link_r    <= 1'b0;
      fef_r     <= 1'b0;
      an_done_r <= 1'b0;
    end else begin
      link_r    <= link_up_i;
      fef_r     <= far_end_fault_i;
      an_done_r <= an_done;
    end
  end

  p2pc_an_seq u_an_seq (
    .clock_i        (clock_i),
    .rst_i          (rst_i),
    .an_enable_i    (ctrl_r[`P2PC_CB_ANEN]),
    .power_down_i   (ctrl_r[`P2PC_CB_PDOWN]),
    .restart_i      (ctrl_r[`P2PC_CB_RESTART]),
    .result_ready_i (an_result_ready_i),
    .link_drop_i    (link_r & ~link_up_i),
    .complete_o     (an_done)
  );

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  assign ev[`P2PC_IB_LINKUP] = ~link_r & link_up_i;
  assign ev[`P2PC_IB_LINKDN] = link_r & ~link_up_i;
  assign ev[`P2PC_IB_ANDONE] = ~an_done_r & an_done;
  assign ev[`P2PC_IB_FEF]    = ~fef_r & far_end_fault_i;
  assign iclr = (wr_go && idx == `P2PC_IDX_ISTAT && avs_byteenable_i[0]) ?
                wdata[`P2PC_IRQ_W-1:0] : '0;

  always_ff @(posedge clock_i) begin
    if (rst_i) ist_r <= '0;
    else ist_r <= (ist_r & ~iclr) | ev;
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) imask_r <= '0;
    else if (wr_go && idx == `P2PC_IDX_IMASK && avs_byteenable_i[0])
      imask_r <= wdata[`P2PC_IRQ_W-1:0];
  end

  assign irq_o = |(ist_r & imask_r);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_loop_wr;
    @(posedge clock_i) disable iff (rst_i)
    wr_go && idx == `P2PC_IDX_CTRL && avs_byteenable_i[1]
      |=> ##1 phy_cfg_o.loopback == $past(avs_writedata_i[14], 2);
  endproperty
  a_loop_wr: assert property (p_loop_wr)
    else $error("Loopback does not follow control write");

  property p_rst_dflt;
    @(posedge clock_i) rst_i |=> ctrl_r[12] && ctrl_r[5] && !ctrl_r[13];
  endproperty
  a_rst_dflt: assert property (p_rst_dflt)
    else $error("Control reset value wrong");

  property p_forced;
    @(posedge clock_i) disable iff (rst_i)
    !ctrl_r[12] |=> phy_cfg_o.speed_100 == $past(ctrl_r[13]) &&
                    phy_cfg_o.full_duplex == $past(ctrl_r[8]);
  endproperty
  a_forced: assert property (p_forced)
    else $error("Forced speed or duplex not applied");

  property p_restart;
    @(posedge clock_i) disable iff (rst_i)
    wr_go && idx == `P2PC_IDX_CTRL && avs_byteenable_i[1] &&
      avs_writedata_i[9] |=> an_restart_o ##1 !an_restart_o;
  endproperty
  a_restart: assert property (p_restart)
    else $error("Restart pulse missing or stuck");

  property p_mdix;
    @(posedge clock_i) disable iff (rst_i)
    ctrl_r[3] || ctrl_r[4] |=> !phy_cfg_o.mdix_auto &&
      phy_cfg_o.mdix_cross == $past(ctrl_r[4]);
  endproperty
  a_mdix: assert property (p_mdix)
    else $error("Crossover override not applied");

  property p_drive_off;
    @(posedge clock_i) disable iff (rst_i)
    ##1 phy_cfg_o.tx_disable == $past(ctrl_r[1]) &&
        phy_cfg_o.power_down == $past(ctrl_r[11]) &&
        phy_cfg_o.led_disable == $past(ctrl_r[0]);
  endproperty
  a_drive_off: assert property (p_drive_off)
    else $error("Transmit, power or indicator control lost");

  property p_stat_rd;
    @(posedge clock_i) disable iff (rst_i)
    rd_go && idx == `P2PC_IDX_STAT |-> rdata_r[3] && !rdata_r[1] &&
      rdata_r[2] == $past(link_r) && rdata_r[4] == $past(fef_r) &&
      rdata_r[5] == $past(an_done);
  endproperty
  a_stat_rd: assert property (p_stat_rd)
    else $error("Status readback wrong");

  property p_ro_zero;
    @(posedge clock_i) disable iff (rst_i)
    rd_go && idx == `P2PC_IDX_CTRL |->
      (rdata_r[15:0] & 16'h84c0) == 16'h0000;
  endproperty
  a_ro_zero: assert property (p_ro_zero)
    else $error("Unsupported control bit reads one");

  property p_irq;
    @(posedge clock_i) disable iff (rst_i)
    ev[0] && imask_r[0] |=> irq_o;
  endproperty
  a_irq: assert property (p_irq)
    else $error("Link-up event raised no interrupt");

  property p_wait;
    @(posedge clock_i) disable iff (rst_i)
    (avs_read_i || avs_write_i) && !ack_r |-> avs_waitrequest_o ##1 ack_r;
  endproperty
  a_wait: assert property (p_wait)
    else $error("Bus answer not in one wait cycle");

  c_ctrl_wr: cover property (@(posedge clock_i) wr_go && idx == 3'h0);
  c_alias_wr: cover property (@(posedge clock_i) wr_go && idx == 3'h6);
  c_an_done: cover property (@(posedge clock_i) $rose(an_done));
  c_irq: cover property (@(posedge clock_i) $rose(irq_o));

endmodule : p2pc_top

`default_nettype wire

// ### test/p2pc_link_model.sv
// Cable link partner model driving the transceiver status inputs
`timescale 1ns/100ps
`default_nettype none

module p2pc_link_model #(
  parameter int DELAY = 4
) (
  input  wire logic clock_i,
  input  wire logic connect_i,
  input  wire logic fault_i,
  output logic      link_up_o,
  output logic      fault_o,
  output logic      ready_o,
  output logic      speed_100_o,
  output logic      full_duplex_o
);
  // ----------------------------------------
  // Link bring-up timing
  // ----------------------------------------
  logic [7:0] cnt_r = 8'h00;

  always @(posedge clock_i) begin
    if (!connect_i)
      cnt_r <= 8'h00;
    else if (cnt_r < 8'(2 * DELAY))
      cnt_r <= cnt_r + 8'h01;
  end

  // Link first, then resolved negotiation offering 100 full
  assign link_up_o     = connect_i && (cnt_r >= 8'(DELAY));
  assign ready_o       = connect_i && (cnt_r >= 8'(2 * DELAY));
  assign speed_100_o   = ready_o;
  assign full_duplex_o = ready_o;
  assign fault_o       = fault_i;
endmodule : p2pc_link_model

`default_nettype wire

// ### test/tb.sv
// Self-checking bench for the port 2 transceiver register bank
`timescale 1ns/100ps
`default_nettype none

module tb;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic               clock_i;
  logic               rst_i;
  logic [4:0]         addr;
  logic               rd;
  logic               wr;
  logic [31:0]        wd;
  logic [31:0]        rdata;
  logic               wreq;
  logic               link_up;
  logic               fault;
  logic               ready;
  logic               sp100;
  logic               fdx;
  p2pc_pkg::phy_cfg_t phy;
  logic               restart;
  logic               irq;
  logic               connect;
  logic               fault_cmd;
  int                 n_errors;
  int                 checks;
  int                 n_rst;
  int                 cyc;

  p2pc_top DUT (
    .clock_i           (clock_i),
    .rst_i             (rst_i),
    .avs_address_i     (addr),
    .avs_read_i        (rd),
    .avs_write_i       (wr),
    .avs_writedata_i   (wd),
    .avs_byteenable_i  (4'hf),
    .avs_readdata_o    (rdata),
    .avs_waitrequest_o (wreq),
    .link_up_i         (link_up),
    .far_end_fault_i   (fault),
    .an_result_ready_i (ready),
    .an_speed_100_i    (sp100),
    .an_full_duplex_i  (fdx),
    .phy_cfg_o         (phy),
    .an_restart_o      (restart),
    .irq_o             (irq)
  );

  p2pc_link_model #(.DELAY(4)) partner (
    .clock_i       (clock_i),
    .connect_i     (connect),
    .fault_i       (fault_cmd),
    .link_up_o     (link_up),
    .fault_o       (fault),
    .ready_o       (ready),
    .speed_100_o   (sp100),
    .full_duplex_o (fdx)
  );

  // ----------------------------------------
  // Clock, monitors, timeout
  // ----------------------------------------
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end

  always @(posedge clock_i) begin
    if (restart === 1'b1)
      n_rst <= n_rst + 1;
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic xfer(input logic w, input logic [4:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge clock_i);
    addr <= a;
    wd   <= d;
    rd   <= !w;
    wr   <= w;
    do @(posedge clock_i); while (wreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : xfer

  task automatic wreg(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : wreg

  task automatic rchk(input string nm, input logic [4:0] a,
                      input logic [31:0] e);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    chk(nm, e, q);
  endtask : rchk

  task automatic settle(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : settle

  task automatic tally_and_finish;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    chk("phy", 32'h094, 32'(phy));
    rchk("ctrl", 5'h00, 32'h1020);
    rchk("stat", 5'h08, 32'h0008);
  endtask : t_reset

  task automatic t_fields;
    wreg(5'h00, 32'hffff);
    rchk("ctrl", 5'h00, 32'h793f);
    settle(3);
    chk("phy", 32'h38f, 32'(phy));
  endtask : t_fields

  task automatic t_force_mdix;
    logic [15:0] cv [5] = '{16'h2100, 16'h0000, 16'h0008, 16'h0010, 16'h0020};
    logic [9:0]  pv [5] = '{10'h070, 10'h010, 10'h000, 10'h008, 10'h014};
    for (int i = 0; i < 5; i++) begin
      wreg(5'h00, 32'(cv[i]));
      settle(3);
      chk("phy", 32'(pv[i]), 32'(phy));
    end
  endtask : t_force_mdix

  task automatic t_restart;
    int r0;
    r0 = n_rst;
    wreg(5'h00, 32'h1200);
    settle(3);
    chk("pulse", 32'(r0 + 1), 32'(n_rst));
    rchk("ctrl", 5'h00, 32'h1000);
    wreg(5'h00, 32'h1000);
    settle(3);
    chk("pulse", 32'(r0 + 1), 32'(n_rst));
  endtask : t_restart

  task automatic t_link_irq;
    wreg(5'h14, 32'hf);
    connect <= 1'b1;
    settle(20);
    rchk("stat", 5'h08, 32'h002c);
    chk("phy", 32'h0f0, 32'(phy));
    chk("irq", 32'h1, 32'(irq));
    rchk("isr", 5'h10, 32'h5);
    wreg(5'h10, 32'h5);
    settle(2);
    chk("irq", 32'h0, 32'(irq));
    rchk("isr", 5'h10, 32'h0);
    wreg(5'h14, 32'h0);
    fault_cmd <= 1'b1;
    settle(5);
    rchk("stat", 5'h08, 32'h003c);
    chk("irq", 32'h0, 32'(irq));
    connect   <= 1'b0;
    fault_cmd <= 1'b0;
    settle(5);
    rchk("stat", 5'h08, 32'h0008);
    rchk("isr", 5'h10, 32'ha);
  endtask : t_link_irq

  task automatic t_alias;
    wreg(5'h18, 32'h0100);
    rchk("ctrl", 5'h00, 32'h4000);
    rchk("alias", 5'h18, 32'h0100);
    settle(3);
    chk("phy", 32'h210, 32'(phy));
    wreg(5'h08, 32'hffff);
    rchk("stat", 5'h08, 32'h0008);
    wreg(5'h1c, 32'hffff);
    rchk("unmapped", 5'h1c, 32'h0);
  endtask : t_alias

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst_i     = 1'b1;
    addr      = 5'h00;
    rd        = 1'b0;
    wr        = 1'b0;
    wd        = 32'h0;
    connect   = 1'b0;
    fault_cmd = 1'b0;
    n_errors  = 0;
    checks    = 0;
    n_rst     = 0;
    cyc       = 0;
    repeat (3) @(posedge clock_i);
    rst_i <= 1'b0;
    settle(1);
    t_reset();
    t_fields();
    t_force_mdix();
    t_restart();
    t_link_irq();
    t_alias();
    tally_and_finish();
  end
endmodule : tb

`default_nettype wire
